// ---- design/fnp_pkg.sv ----
// shared constants and types for the non-secure flash program control block
package fnp_pkg;

   // =======================================
   // clock and timing
   localparam int unsigned CLK_MHZ      = 100;
   localparam int unsigned T_WRITE_US   = 43;
   localparam int unsigned T_PAGE_MS    = 87;
   localparam int unsigned T_ALL_MS     = 173;
   localparam real         T_PSETUP_MS  = 1.08;
   // fractional times round down to whole cycles
   localparam int unsigned WR_CYC = T_WRITE_US * CLK_MHZ;
   localparam int unsigned MS_CYC = 1000 * CLK_MHZ;
   localparam int unsigned PG_CYC = T_PAGE_MS * MS_CYC;
   localparam int unsigned AL_CYC = T_ALL_MS * MS_CYC;
   localparam int unsigned PS_CYC = $rtoi(T_PSETUP_MS * 1000.0 * CLK_MHZ + 0.001);

   // =======================================
   // register offsets (byte addresses)
   localparam logic [11:0] A_READY = 12'h400;
   localparam logic [11:0] A_RDYNX = 12'h408;
   localparam logic [11:0] A_MODE  = 12'h584;
   localparam logic [11:0] A_LOCK  = 12'h588;
   localparam logic [11:0] A_PCFG  = 12'h600;
   localparam logic [11:0] A_CMD   = 12'h604;
   localparam logic [11:0] A_STAT  = 12'h608;

   // =======================================
   // fields and reset values
   localparam logic [27:0] LOCK_KEY  = 28'hAFB_E5A7;
   localparam int unsigned KEY_LSB   = 4;
   localparam int unsigned PDUR_W    = 7;
   localparam logic [6:0]  PDUR_RST  = 7'h0A;
   localparam int unsigned ST_IGN    = 0;
   localparam int unsigned ST_LOCK   = 1;
   localparam int unsigned ST_CINV   = 2;

   typedef enum logic [2:0] {
      MODE_RO = 3'b000,
      MODE_WR = 3'b001,
      MODE_ER = 3'b010,
      MODE_PE = 3'b100
   } fnp_mode_t;

   typedef enum logic [2:0] {
      OP_NONE = 3'h0,
      OP_WORD = 3'h1,
      OP_PAGE = 3'h2,
      OP_ALL  = 3'h3,
      OP_PART = 3'h4
   } fnp_op_t;

   typedef enum logic [0:0] {
      BS_IDLE = 1'b0,
      BS_DATA = 1'b1
   } fnp_bus_st_t;

   typedef struct packed {
      logic        wr;
      logic [11:0] addr;
      logic [31:0] wdata;
   } fnp_acc_t;

   typedef struct packed {
      logic    go;
      fnp_op_t op;
   } fnp_cmd_t;

endpackage

// ---- design/fnp_ahb_slave.sv ----
// ahb-lite slave front end: one wait state, registered read data
module fnp_ahb_slave (
   // clock and reset
   input  logic                clock,
   input  logic                rst,
   // ahb-lite
   input  logic                hsel,
   input  logic [31:0]         haddr,
   input  logic [1:0]          htrans,
   input  logic                hwrite,
   input  logic [2:0]          hsize,
   input  logic [31:0]         hwdata,
   input  logic                hready,
   output logic                hreadyout,
   output logic                hresp,
   output logic [31:0]         hrdata,
   // register side
   output fnp_pkg::fnp_acc_t   acc,
   input  logic [31:0]         rdata
);

   fnp_pkg::fnp_bus_st_t st_r, st_nxt;
   fnp_pkg::fnp_acc_t    acc_r, acc_nxt;
   logic                 wf_r, wf_nxt;
   logic                 rdy_r, rdy_nxt;
   logic [31:0]          rd_r, rd_nxt;

   // =======================================
   // transfer sequencing
   // the wait state lets read data come from a flop
   always_comb begin
      st_nxt     = st_r;
      acc_nxt    = acc_r;
      acc_nxt.wr = 1'b0;
      wf_nxt     = wf_r;
      rdy_nxt    = rdy_r;
      rd_nxt     = rd_r;
      case (st_r)
         fnp_pkg::BS_IDLE: begin
            if (hsel && htrans[1] && hready) begin
               acc_nxt.addr = haddr[11:0];
               wf_nxt       = hwrite;
               rdy_nxt      = 1'b0;
               st_nxt       = fnp_pkg::BS_DATA;
            end
         end
         fnp_pkg::BS_DATA: begin
            acc_nxt.wr    = wf_r;
            acc_nxt.wdata = hwdata;
            if (!wf_r) begin
               rd_nxt = rdata;
            end
            rdy_nxt = 1'b1;
            st_nxt  = fnp_pkg::BS_IDLE;
         end
         default: begin
            st_nxt  = fnp_pkg::BS_IDLE;
            rdy_nxt = 1'b1;
         end
      endcase
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         st_r  <= fnp_pkg::BS_IDLE;
         acc_r <= '0;
         wf_r  <= 1'b0;
         rdy_r <= 1'b1;
         rd_r  <= 32'h0000_0000;
         hresp <= 1'b0;
      end else begin
         st_r  <= st_nxt;
         acc_r <= acc_nxt;
         wf_r  <= wf_nxt;
         rdy_r <= rdy_nxt;
         rd_r  <= rd_nxt;
         hresp <= 1'b0;
      end
   end

   assign hreadyout = rdy_r;
   assign hrdata    = rd_r;
   assign acc       = acc_r;

endmodule

// ---- design/fnp_op_timer.sv ----
// countdown timer that holds busy for a loaded number of cycles
module fnp_op_timer #(
   parameter int unsigned W = 32
) (
   // clock and reset
   input  logic         clock,
   input  logic         rst,
   // control
   input  logic         load,
   input  logic [W-1:0] count,
   output logic         busy
);

   logic [W-1:0] cnt_r, cnt_nxt;
   logic         busy_r, busy_nxt;

   always_comb begin
      cnt_nxt = cnt_r;
      if (load) begin
         cnt_nxt = count;
      end else if (cnt_r != '0) begin
         cnt_nxt = cnt_r - W'(1);
      end
      busy_nxt = (cnt_nxt != '0);
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         cnt_r  <= '0;
         busy_r <= 1'b0;
      end else begin
         cnt_r  <= cnt_nxt;
         busy_r <= busy_nxt;
      end
   end

   assign busy = busy_r;

endmodule

// ---- design/fnp_ctrl.sv ----
// non-secure flash program control: access mode, lock request, operation timing
module fnp_ctrl #(
   parameter int unsigned WR_CYC = fnp_pkg::WR_CYC,
   parameter int unsigned PG_CYC = fnp_pkg::PG_CYC,
   parameter int unsigned AL_CYC = fnp_pkg::AL_CYC,
   parameter int unsigned PS_CYC = fnp_pkg::PS_CYC,
   parameter int unsigned MS_CYC = fnp_pkg::MS_CYC
) (
   // clock and reset
   input  logic               clock,
   input  logic               rst,
   // ahb-lite register port
   input  logic               hsel,
   input  logic [31:0]        haddr,
   input  logic [1:0]         htrans,
   input  logic               hwrite,
   input  logic [2:0]         hsize,
   input  logic [31:0]        hwdata,
   input  logic               hready,
   output logic               hreadyout,
   output logic               hresp,
   output logic [31:0]        hrdata,
   // flash array side
   output fnp_pkg::fnp_cmd_t  flash_cmd,
   output logic               flash_busy,
   // system side
   output logic               cache_invalid,
   output logic               debug_port_lock
);

   // =======================================
   // bus front end
   fnp_pkg::fnp_acc_t acc;
   logic [31:0]       rdata;

   fnp_ahb_slave fnp_ahb_slave_i (
      .clock     (clock),
      .rst       (rst),
      .hsel      (hsel),
      .haddr     (haddr),
      .htrans    (htrans),
      .hwrite    (hwrite),
      .hsize     (hsize),
      .hwdata    (hwdata),
      .hready    (hready),
      .hreadyout (hreadyout),
      .hresp     (hresp),
      .hrdata    (hrdata),
      .acc       (acc),
      .rdata     (rdata)
   );

   // =======================================
   // state
   fnp_pkg::fnp_mode_t       mode_r, mode_nxt;
   logic                     lock_r, lock_nxt;
   logic [fnp_pkg::PDUR_W-1:0] pdur_r, pdur_nxt;
   logic                     ign_r, ign_nxt;
   logic                     cinv_r, cinv_nxt;
   fnp_pkg::fnp_cmd_t        cmd_r, cmd_nxt;
   fnp_pkg::fnp_op_t         cur_r, cur_nxt;
   logic [31:0]              len_nxt;
   logic                     busy;

   logic                     w_mode, w_lock, w_pcfg, w_cmd, w_stat;
   fnp_pkg::fnp_op_t         req_op;
   logic                     permit;

   assign w_mode = acc.wr && (acc.addr == fnp_pkg::A_MODE);
   assign w_lock = acc.wr && (acc.addr == fnp_pkg::A_LOCK);
   assign w_pcfg = acc.wr && (acc.addr == fnp_pkg::A_PCFG);
   assign w_cmd  = acc.wr && (acc.addr == fnp_pkg::A_CMD);
   assign w_stat = acc.wr && (acc.addr == fnp_pkg::A_STAT);
   assign req_op = fnp_pkg::fnp_op_t'(acc.wdata[2:0]);

   // =======================================
   // mode-gated operation permission
   always_comb begin
      case (req_op)
         fnp_pkg::OP_WORD: permit = (mode_r == fnp_pkg::MODE_WR);
         fnp_pkg::OP_PAGE: permit = (mode_r == fnp_pkg::MODE_ER);
         fnp_pkg::OP_ALL:  permit = (mode_r == fnp_pkg::MODE_ER);
         fnp_pkg::OP_PART: permit = (mode_r == fnp_pkg::MODE_PE);
         default:          permit = 1'b0;
      endcase
   end

   // =======================================
   // next-state of the control registers
   always_comb begin
      mode_nxt = mode_r;
      lock_nxt = lock_r;
      pdur_nxt = pdur_r;
      ign_nxt  = ign_r;
      cmd_nxt  = '{go: 1'b0, op: cmd_r.op};
      cur_nxt  = cur_r;
      if (w_mode) begin
         // values other than zero or a single set bit leave the mode untouched
         case (acc.wdata[2:0])
            fnp_pkg::MODE_RO,
            fnp_pkg::MODE_WR,
            fnp_pkg::MODE_ER,
            fnp_pkg::MODE_PE: mode_nxt = fnp_pkg::fnp_mode_t'(acc.wdata[2:0]);
            default:          mode_nxt = mode_r;
         endcase
      end
      if (w_lock && acc.wdata[0] &&
          (acc.wdata[31:fnp_pkg::KEY_LSB] == fnp_pkg::LOCK_KEY)) begin
         lock_nxt = 1'b1;
      end
      if (w_pcfg) begin
         pdur_nxt = acc.wdata[fnp_pkg::PDUR_W-1:0];
      end
      if (w_stat && acc.wdata[fnp_pkg::ST_IGN]) begin
         ign_nxt = 1'b0;
      end
      // a refused request sets the flag; the set wins over a clear
      if (w_cmd && (req_op != fnp_pkg::OP_NONE)) begin
         if (permit && !busy) begin
            cmd_nxt = '{go: 1'b1, op: req_op};
            cur_nxt = req_op;
         end else begin
            ign_nxt = 1'b1;
         end
      end
      // cache follows the mode being applied, so it is invalid from the same edge
      cinv_nxt = (mode_nxt != fnp_pkg::MODE_RO);
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         mode_r <= fnp_pkg::MODE_RO;
         lock_r <= 1'b0;
         pdur_r <= fnp_pkg::PDUR_RST;
         ign_r  <= 1'b0;
         cinv_r <= 1'b0;
         cmd_r  <= '{go: 1'b0, op: fnp_pkg::OP_NONE};
         cur_r  <= fnp_pkg::OP_NONE;
      end else begin
         mode_r <= mode_nxt;
         lock_r <= lock_nxt;
         pdur_r <= pdur_nxt;
         ign_r  <= ign_nxt;
         cinv_r <= cinv_nxt;
         cmd_r  <= cmd_nxt;
         cur_r  <= cur_nxt;
      end
   end

   // =======================================
   // operation timing
   // each figure is the worst case; busy lasts exactly that long
   always_comb begin
      case (cmd_r.op)
         fnp_pkg::OP_WORD: len_nxt = 32'(WR_CYC);
         fnp_pkg::OP_PAGE: len_nxt = 32'(PG_CYC);
         fnp_pkg::OP_ALL:  len_nxt = 32'(AL_CYC);
         fnp_pkg::OP_PART: len_nxt = 32'(pdur_r) * 32'(MS_CYC) + 32'(PS_CYC);
         default:          len_nxt = 32'h0000_0001;
      endcase
   end

   fnp_op_timer #(
      .W (32)
   ) fnp_op_timer_i (
      .clock (clock),
      .rst   (rst),
      .load  (cmd_r.go),
      .count (len_nxt),
      .busy  (busy)
   );

   // =======================================
   // register read mux
   // busy is also seen during the start pulse so no second start slips in
   logic idle;
   assign idle = !busy && !cmd_r.go;

   always_comb begin
      rdata = 32'h0000_0000;
      case (acc.addr)
         fnp_pkg::A_READY: rdata[0] = idle;
         fnp_pkg::A_RDYNX: rdata[0] = idle;
         fnp_pkg::A_MODE:  rdata[2:0] = mode_r;
         fnp_pkg::A_PCFG:  rdata[fnp_pkg::PDUR_W-1:0] = pdur_r;
         fnp_pkg::A_STAT: begin
            rdata[fnp_pkg::ST_IGN]  = ign_r;
            rdata[fnp_pkg::ST_LOCK] = lock_r;
            rdata[fnp_pkg::ST_CINV] = cinv_r;
         end
         default: rdata = 32'h0000_0000;
      endcase
   end

   assign flash_cmd       = cmd_r;
   assign flash_busy      = busy;
   assign cache_invalid   = cinv_r;
   assign debug_port_lock = lock_r;

   // =======================================
   // checks
   logic [31:0] blen_r;
   logic [31:0] plim_r;

   always_ff @(posedge clock) begin
      if (rst) begin
         blen_r <= 32'h0000_0000;
         plim_r <= 32'h0000_0000;
      end else if (cmd_r.go) begin
         blen_r <= 32'h0000_0000;
         plim_r <= len_nxt;
      end else if (busy) begin
         blen_r <= blen_r + 32'h0000_0001;
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   a_mode_onehot: assert property ($onehot0(mode_r))
      else $error("access mode not one-hot");
   a_mode_reject: assert property (
      w_mode && acc.wdata[2:0] == 3'h3 |=> $stable(mode_r))
      else $error("illegal mode value accepted");
   a_mode_part: assert property (
      w_mode && acc.wdata[2:0] == 3'h4 |=> mode_r == fnp_pkg::MODE_PE)
      else $error("partial erase mode not taken");
   a_cache_hold: assert property (
      mode_r != fnp_pkg::MODE_RO |-> cinv_r)
      else $error("cache valid in write or erase mode");
   a_lock_key: assert property (
      w_lock && acc.wdata[31:4] != fnp_pkg::LOCK_KEY && !lock_r |=> !lock_r)
      else $error("lock armed by bad key");
   a_lock_set: assert property (
      w_lock && acc.wdata[0] && acc.wdata[31:4] == fnp_pkg::LOCK_KEY |=> lock_r)
      else $error("lock not armed by valid key");
   a_op_ignored: assert property (
      w_cmd && mode_r == fnp_pkg::MODE_RO |=> !cmd_r.go ##1 !busy)
      else $error("operation started in read mode");
   a_word_time: assert property (
      $fell(busy) && cur_r == fnp_pkg::OP_WORD |-> blen_r <= 32'(WR_CYC))
      else $error("word write too long");
   a_page_time: assert property (
      $fell(busy) && cur_r == fnp_pkg::OP_PAGE |-> blen_r <= 32'(PG_CYC))
      else $error("page erase too long");
   a_all_time: assert property (
      $fell(busy) && cur_r == fnp_pkg::OP_ALL |-> blen_r <= 32'(AL_CYC))
      else $error("chip erase too long");
   a_part_time: assert property (
      $fell(busy) && cur_r == fnp_pkg::OP_PART |-> blen_r <= plim_r)
      else $error("partial erase too long");
   a_ready_flag: assert property (
      cmd_r.go |=> busy ##0 (acc.addr != fnp_pkg::A_READY || rdata[0] == 1'b0))
      else $error("ready flag set while busy");
   a_next_flag: assert property (
      !busy && !cmd_r.go && acc.addr == fnp_pkg::A_RDYNX |-> rdata == 32'h0000_0001)
      else $error("accept-next flag low while idle");

endmodule

// ---- tb/fnp_ctrl_test.sv ----
// self-checking bench for the non-secure flash program control block
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin mismatches++; $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end

module fnp_ctrl_test;
   timeunit 1ns;
   timeprecision 1ps;

   // =======================================
   // shortened operation lengths
   localparam int unsigned WR_N = 20;
   localparam int unsigned PG_N = 40;
   localparam int unsigned AL_N = 60;
   localparam int unsigned MS_N = 10;
   localparam int unsigned PS_N = 5;

   logic               clock;
   logic               rst;
   logic               hsel;
   logic [31:0]        haddr;
   logic [1:0]         htrans;
   logic               hwrite;
   logic [2:0]         hsize;
   logic [31:0]        hwdata;
   logic               hready;
   logic               hreadyout;
   logic               hresp;
   logic [31:0]        hrdata;
   fnp_pkg::fnp_cmd_t  flash_cmd;
   logic               flash_busy;
   logic               cache_invalid;
   logic               debug_port_lock;
   int                 mismatches = 0;
   int                 checks_done = 0;
   int                 busy_cnt = 0;
   int                 go_cnt = 0;
   logic [2:0]         modes [3] = '{3'h1, 3'h2, 3'h4};

   assign hready = hreadyout;

   fnp_ctrl #(
      .WR_CYC (WR_N),
      .PG_CYC (PG_N),
      .AL_CYC (AL_N),
      .PS_CYC (PS_N),
      .MS_CYC (MS_N)
   ) fnp_ctrl_i (
      .clock           (clock),
      .rst             (rst),
      .hsel            (hsel),
      .haddr           (haddr),
      .htrans          (htrans),
      .hwrite          (hwrite),
      .hsize           (hsize),
      .hwdata          (hwdata),
      .hready          (hready),
      .hreadyout       (hreadyout),
      .hresp           (hresp),
      .hrdata          (hrdata),
      .flash_cmd       (flash_cmd),
      .flash_busy      (flash_busy),
      .cache_invalid   (cache_invalid),
      .debug_port_lock (debug_port_lock)
   );

   // =======================================
   // clock and activity counters
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   // counting on edges keeps pulse widths measurable without polling races
   always @(posedge clock) begin
      if (flash_busy === 1'b1) busy_cnt <= busy_cnt + 1;
      if (flash_cmd.go === 1'b1) go_cnt <= go_cnt + 1;
   end

   // =======================================
   // bus tasks
   task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      int i;
      @(posedge clock);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      hwrite <= wr;
      haddr  <= {20'h0_0000, a};
      @(posedge clock);
      for (i = 0; i < 50 && hreadyout !== 1'b1; i++) @(posedge clock);
      `CHK(hreadyout, 1'b1)
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      @(posedge clock);
      for (i = 0; i < 50 && hreadyout !== 1'b1; i++) @(posedge clock);
      `CHK(hreadyout, 1'b1)
      q = hrdata;
      `CHK(hresp, 1'b0)
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask

   task automatic rd(input logic [11:0] a, output logic [31:0] q);
      bus(1'b0, a, 32'h0000_0000, q);
   endtask

   // start one operation, watch flags while busy, then measure the busy span
   task automatic run_op(input logic [2:0] op, input int n);
      logic [31:0] d;
      int          b0;
      int          g0;
      int          i;
      b0 = busy_cnt;
      g0 = go_cnt;
      wr(fnp_pkg::A_CMD, {29'h0000_0000, op});
      rd(fnp_pkg::A_READY, d);
      `CHK(d, 32'h0000_0000)
      rd(fnp_pkg::A_RDYNX, d);
      `CHK(d, 32'h0000_0000)
      // a second start while busy must be refused
      wr(fnp_pkg::A_CMD, {29'h0000_0000, op});
      for (i = 0; i < 1000 && flash_busy !== 1'b0; i++) @(posedge clock);
      @(posedge clock);
      `CHK(flash_busy, 1'b0)
      `CHK(go_cnt - g0, 1)
      `CHK(flash_cmd.op, op)
      `CHK((busy_cnt - b0 >= n - 1) && (busy_cnt - b0 <= n), 1'b1)
      rd(fnp_pkg::A_READY, d);
      `CHK(d, 32'h0000_0001)
      rd(fnp_pkg::A_STAT, d);
      `CHK(d[0], 1'b1)
      wr(fnp_pkg::A_STAT, 32'h0000_0001);
   endtask

   task test_done();
      $display("checks %0d, mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // =======================================
   // watchdog
   initial begin
      repeat (20000) @(posedge clock);
      mismatches++;
      test_done();
   end

   // =======================================
   // tests
   initial begin
      logic [31:0] d;
      int          i;
      int          g;
      rst    = 1'b1;
      hsel   = 1'b0;
      haddr  = 32'h0000_0000;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize  = 3'b010;
      hwdata = 32'h0000_0000;
      repeat (20) @(posedge clock);
      rst <= 1'b0;
      rd(fnp_pkg::A_READY, d);
      `CHK(d, 32'h0000_0001)
      rd(fnp_pkg::A_RDYNX, d);
      `CHK(d, 32'h0000_0001)
      rd(fnp_pkg::A_MODE, d);
      `CHK(d, 32'h0000_0000)
      rd(fnp_pkg::A_PCFG, d);
      `CHK(d, {25'h000_0000, fnp_pkg::PDUR_RST})
      rd(12'h500, d);
      `CHK(d, 32'h0000_0000)
      // each write or erase mode reads back; a non-one-hot value leaves it alone
      for (i = 0; i < 3; i++) begin
         wr(fnp_pkg::A_MODE, {29'h0000_0000, modes[i]});
         wr(fnp_pkg::A_MODE, 32'h0000_0003);
         rd(fnp_pkg::A_MODE, d);
         `CHK(d, {29'h0000_0000, modes[i]})
         `CHK(cache_invalid, 1'b1)
      end
      wr(fnp_pkg::A_MODE, 32'h0000_0000);
      rd(fnp_pkg::A_MODE, d);
      `CHK(cache_invalid, 1'b0)
      // command refused in read-only mode
      g = go_cnt;
      wr(fnp_pkg::A_CMD, 32'h0000_0001);
      rd(fnp_pkg::A_STAT, d);
      `CHK(d, 32'h0000_0001)
      `CHK(go_cnt - g, 0)
      wr(fnp_pkg::A_STAT, 32'h0000_0001);
      // the no-op code is neither started nor refused
      wr(fnp_pkg::A_CMD, 32'h0000_0000);
      rd(fnp_pkg::A_STAT, d);
      `CHK(d, 32'h0000_0000)
      wr(fnp_pkg::A_MODE, 32'h0000_0001);
      // one word write in write mode, with its busy span measured
      run_op(3'h1, WR_N);
      // erase refused while only writing is enabled
      g = go_cnt;
      wr(fnp_pkg::A_CMD, 32'h0000_0002);
      rd(fnp_pkg::A_STAT, d);
      `CHK(d, 32'h0000_0005)
      `CHK(go_cnt - g, 0)
      wr(fnp_pkg::A_STAT, 32'h0000_0001);
      wr(fnp_pkg::A_MODE, 32'h0000_0002);
      run_op(3'h2, PG_N);
      run_op(3'h3, AL_N);
      wr(fnp_pkg::A_PCFG, 32'h0000_0002);
      wr(fnp_pkg::A_MODE, 32'h0000_0004);
      run_op(3'h4, 2 * MS_N + PS_N);
      wr(fnp_pkg::A_MODE, 32'h0000_0000);
      // lock request: wrong key, then good key without the set bit, then armed
      wr(fnp_pkg::A_LOCK, {28'h123_4567, 4'h1});
      wr(fnp_pkg::A_LOCK, {fnp_pkg::LOCK_KEY, 4'h0});
      rd(fnp_pkg::A_STAT, d);
      `CHK(d, 32'h0000_0000)
      `CHK(debug_port_lock, 1'b0)
      wr(fnp_pkg::A_LOCK, {fnp_pkg::LOCK_KEY, 4'h1});
      rd(fnp_pkg::A_STAT, d);
      `CHK(d, 32'h0000_0002)
      `CHK(debug_port_lock, 1'b1)
      rd(fnp_pkg::A_LOCK, d);
      `CHK(d, 32'h0000_0000)
      test_done();
   end
endmodule
